// ---- logic/ecsr_map.svh ----
// register map, bit positions, reset values and timing counts of the
// e1 converter status/control slice; definitions only
`ifndef ECSR_MAP_SVH
`define ECSR_MAP_SVH

// register indices; byte address is four times the index
`define ECSR_IDX_ALARM 8'h0F
`define ECSR_IDX_CRC 8'h10
`define ECSR_IDX_CV_HI 8'h11
`define ECSR_IDX_CV_LO 8'h12
`define ECSR_IDX_DEV_ID 8'h13
`define ECSR_IDX_USER_TX 8'h14
`define ECSR_IDX_USER_PIN 8'h15
`define ECSR_IDX_RSV_A 8'h16
`define ECSR_IDX_RSV_B 8'h17
`define ECSR_IDX_CTRL 8'h18
`define ECSR_IDX_LATCH 8'h20
`define ECSR_IDX_MASK 8'h21
`define ECSR_IDX_REMOTE 8'h22

// control register bits
`define ECSR_CTRL_LOOP 7
`define ECSR_CTRL_BERT 6
`define ECSR_CTRL_SRST 5
`define ECSR_CTRL_SREN 4

// remote status bits
`define ECSR_REM_UNFRAMED 0
`define ECSR_REM_SA_SEL 1

// reset values
`define ECSR_RST_BYTE 8'h00
`define ECSR_RST_CV 16'h0000

// axi responses
`define ECSR_RESP_OKAY 2'b00
`define ECSR_RESP_SLVERR 2'b10

// timing
`define ECSR_CLK_PERIOD_NS 10
`define ECSR_SRST_NS 160
`define ECSR_SRST_CYCLES (`ECSR_SRST_NS / `ECSR_CLK_PERIOD_NS)
`define ECSR_RATE_WIN_NS 640
`define ECSR_RATE_WIN_CYCLES (`ECSR_RATE_WIN_NS / `ECSR_CLK_PERIOD_NS)
`define ECSR_RATE_THRESHOLD 6'h08
`define ECSR_STRAP_SETTLE 2'h2

`endif

// ---- logic/ecsr_pkg.sv ----
// types shared by the e1 converter status/control slice
// assumes ecsr_map.svh supplies every number
package ecsr_pkg;

  // live e1 framing alarms, one bit each, high while present
  typedef struct packed {
    logic los;
    logic ais;
    logic lomf;
    logic lof;
    logic crc_err;
    logic ral;
  } ecsr_alarm_type;

  // outgoing control levels
  typedef struct packed {
    logic wan_loopback;
    logic bert_enable;
    logic soft_reset;
  } ecsr_ctrl_type;

  typedef enum logic [1:0] {
    SR_IDLE = 2'b01,
    SR_BUSY = 2'b10
  } ecsr_srst_state_type;

endpackage

// ---- logic/ecsr_regs.sv ----
// status and control register slice of an ethernet-over-e1 converter,
// reached over an axi4-lite slave with 32-bit data, low byte used.
// assumes framer, sa deframer and pulse sources run on aclk; strap pins
// and the phy receive clock are asynchronous and are synchronised here.
`include "ecsr_map.svh"

module ecsr_regs (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  input wire logic [9:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [9:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire ecsr_pkg::ecsr_alarm_type e1_alarm,
  input wire logic crc_err_pulse,
  input wire logic cv_pulse,
  input wire logic phy_rx_clk,
  input wire logic sa_usage_select,
  input wire logic remote_valid,
  input wire logic remote_unframed_status,
  input wire logic [15:0] strap_input_pins,
  output logic [7:0] local_user_info_out,
  output ecsr_pkg::ecsr_ctrl_type ctrl_out,
  output logic irq
);
  import ecsr_pkg::*;

  localparam int STRAP_W = 16;

  logic [STRAP_W-1:0] strap_sync;
  logic phy_m_q, phy_s_q, phy_p_q;
  logic [1:0] strap_cnt_q;
  logic [7:0] dev_id_q, user_pin_q;
  logic [5:0] win_cnt_q, edge_cnt_q;
  logic speed_q;
  logic [7:0] crc_error_count_q;
  logic [15:0] code_violation_count_q;
  ecsr_alarm_type alarm_p_q;
  logic rvalid_p_q, speed_p_q;
  logic [7:0] latch_q, latch_d, mask_q, events;
  logic [7:0] live_alarm;
  logic loop_q, bert_q, sren_q, srst_cmd_q;
  ecsr_srst_state_type sr_state_q;
  logic [4:0] sr_cnt_q;
  logic aw_have_q, w_have_q;
  logic [7:0] aw_idx_q, w_byte_q;
  logic w_lane_q;
  logic wr_fire, wr_en;
  logic [7:0] rd_byte;
  logic rd_ok, wr_ok;

  // straps are static pins: two flops each before anything looks
  for (genvar g = 0; g < STRAP_W; g++)
  begin : g_strap
    logic m_q, s_q;
    always_ff @(posedge aclk)
    begin
      if (!aresetn)
      begin
        m_q <= 1'b0;
        s_q <= 1'b0;
      end
      else if (clk_en)
      begin
        m_q <= strap_input_pins[g];
        s_q <= m_q;
      end
    end
    assign strap_sync[g] = s_q;
  end

  // sample only once the synchronisers hold the pins, not their reset zeros;
  // straps are static, so following them afterwards is harmless
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      strap_cnt_q <= 2'h0;
      dev_id_q <= `ECSR_RST_BYTE;
      user_pin_q <= `ECSR_RST_BYTE;
    end
    else if (clk_en && strap_cnt_q != `ECSR_STRAP_SETTLE)
      strap_cnt_q <= strap_cnt_q + 2'h1;
    else if (clk_en)
    begin
      dev_id_q <= strap_sync[15:8];
      user_pin_q <= strap_sync[7:0];
    end
  end

  // phy receive clock sampled as data; 25 MHz gives ~16 edges per
  // window, 2.5 MHz at most 2, so a mid threshold is robust
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      phy_m_q <= 1'b0;
      phy_s_q <= 1'b0;
      phy_p_q <= 1'b0;
    end
    else if (clk_en)
    begin
      phy_m_q <= phy_rx_clk;
      phy_s_q <= phy_m_q;
      phy_p_q <= phy_s_q;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      win_cnt_q <= 6'h00;
      edge_cnt_q <= 6'h00;
      speed_q <= 1'b0;
    end
    else if (clk_en)
    begin
      if (win_cnt_q == 6'(`ECSR_RATE_WIN_CYCLES - 1))
      begin
        win_cnt_q <= 6'h00;
        edge_cnt_q <= 6'h00;
        speed_q <= (edge_cnt_q >= `ECSR_RATE_THRESHOLD);
      end
      else
      begin
        win_cnt_q <= win_cnt_q + 6'h01;
        if (phy_s_q && !phy_p_q && edge_cnt_q != 6'h3F)
          edge_cnt_q <= edge_cnt_q + 6'h01;
      end
    end
  end

  // error counters saturate rather than wrap so a long outage stays visible
  always_ff @(posedge aclk)
  begin
    if (!aresetn || (clk_en && ctrl_out.soft_reset))
    begin
      crc_error_count_q <= `ECSR_RST_BYTE;
      code_violation_count_q <= `ECSR_RST_CV;
    end
    else if (clk_en)
    begin
      if (crc_err_pulse && crc_error_count_q != 8'hFF)
        crc_error_count_q <= crc_error_count_q + 8'h01;
      if (cv_pulse && code_violation_count_q != 16'hFFFF)
        code_violation_count_q <= code_violation_count_q + 16'h0001;
    end
  end

  // live alarm byte, layout of the alarm register
  assign live_alarm = {e1_alarm.los, e1_alarm.ais, e1_alarm.lomf,
                       e1_alarm.lof, e1_alarm.crc_err, e1_alarm.ral,
                       speed_q, remote_valid};

  // rising alarms, any speed change, loss of far-end frame
  assign events = {live_alarm[7:2] & ~{alarm_p_q.los, alarm_p_q.ais,
                   alarm_p_q.lomf, alarm_p_q.lof, alarm_p_q.crc_err,
                   alarm_p_q.ral},
                   speed_q ^ speed_p_q,
                   rvalid_p_q & ~remote_valid};

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      alarm_p_q <= '0;
      speed_p_q <= 1'b0;
      rvalid_p_q <= 1'b0;
    end
    else if (clk_en)
    begin
      alarm_p_q <= e1_alarm;
      speed_p_q <= speed_q;
      rvalid_p_q <= remote_valid;
    end
  end

  // a new event wins over a write-one clear in the same cycle
  always_comb
  begin
    latch_d = latch_q;
    if (wr_en && aw_idx_q == `ECSR_IDX_LATCH)
      latch_d = latch_d & ~w_byte_q;
    latch_d = latch_d | events;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn || (clk_en && ctrl_out.soft_reset))
      latch_q <= `ECSR_RST_BYTE;
    else if (clk_en)
      latch_q <= latch_d;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      mask_q <= `ECSR_RST_BYTE;
      irq <= 1'b0;
    end
    else if (clk_en)
    begin
      if (wr_en && aw_idx_q == `ECSR_IDX_MASK)
        mask_q <= w_byte_q;
      irq <= |(latch_q & mask_q);
    end
  end

  // user byte and control levels
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      local_user_info_out <= `ECSR_RST_BYTE;
      loop_q <= 1'b0;
      bert_q <= 1'b0;
      sren_q <= 1'b0;
    end
    else if (clk_en && wr_en)
    begin
      if (aw_idx_q == `ECSR_IDX_USER_TX)
        local_user_info_out <= w_byte_q;
      if (aw_idx_q == `ECSR_IDX_CTRL)
      begin
        loop_q <= w_byte_q[`ECSR_CTRL_LOOP];
        bert_q <= w_byte_q[`ECSR_CTRL_BERT];
        sren_q <= w_byte_q[`ECSR_CTRL_SREN];
      end
    end
  end

  // software reset; enable must already be set before the trigger write
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sr_state_q <= SR_IDLE;
      sr_cnt_q <= 5'h00;
      srst_cmd_q <= 1'b0;
    end
    else if (clk_en)
    begin
      case (sr_state_q)
        SR_IDLE:
        begin
          if (wr_en && aw_idx_q == `ECSR_IDX_CTRL &&
              w_byte_q[`ECSR_CTRL_SRST] && sren_q)
          begin
            sr_state_q <= SR_BUSY;
            sr_cnt_q <= 5'h00;
            srst_cmd_q <= 1'b1;
          end
        end
        SR_BUSY:
        begin
          if (sr_cnt_q == 5'(`ECSR_SRST_CYCLES - 1))
          begin
            sr_state_q <= SR_IDLE;
            srst_cmd_q <= 1'b0;
          end
          else
            sr_cnt_q <= sr_cnt_q + 5'h01;
        end
        default:
        begin
          sr_state_q <= SR_IDLE;
          srst_cmd_q <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      ctrl_out <= '0;
    else if (clk_en)
    begin
      ctrl_out.wan_loopback <= loop_q;
      ctrl_out.bert_enable <= bert_q;
      ctrl_out.soft_reset <= srst_cmd_q;
    end
  end

  // write channel: address and data taken independently, any order
  assign wr_fire = aw_have_q && w_have_q && !s_axi_bvalid;
  assign wr_en = wr_fire && w_lane_q;

  always_comb
  begin
    wr_ok = 1'b1;
    if (aw_idx_q > `ECSR_IDX_CTRL && aw_idx_q != `ECSR_IDX_LATCH &&
        aw_idx_q != `ECSR_IDX_MASK && aw_idx_q != `ECSR_IDX_REMOTE)
      wr_ok = 1'b0;
    if (aw_idx_q < `ECSR_IDX_ALARM)
      wr_ok = 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      aw_idx_q <= 8'h00;
      w_byte_q <= 8'h00;
      w_lane_q <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `ECSR_RESP_OKAY;
    end
    else if (clk_en)
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_have_q <= 1'b1;
        aw_idx_q <= s_axi_awaddr[9:2];
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_have_q <= 1'b1;
        w_byte_q <= s_axi_wdata[7:0];
        w_lane_q <= s_axi_wstrb[0];
        s_axi_wready <= 1'b0;
      end
      if (wr_fire)
      begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        // read-only targets accept silently, unmapped ones error
        s_axi_bresp <= wr_ok ? `ECSR_RESP_OKAY : `ECSR_RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // read decode; reserved and unused bits read zero
  always_comb
  begin
    rd_byte = 8'h00;
    rd_ok = 1'b1;
    case (s_axi_araddr[9:2])
      `ECSR_IDX_ALARM: rd_byte = live_alarm;
      `ECSR_IDX_CRC: rd_byte = crc_error_count_q;
      `ECSR_IDX_CV_HI: rd_byte = code_violation_count_q[15:8];
      `ECSR_IDX_CV_LO: rd_byte = code_violation_count_q[7:0];
      `ECSR_IDX_DEV_ID: rd_byte = dev_id_q;
      `ECSR_IDX_USER_TX: rd_byte = local_user_info_out;
      `ECSR_IDX_USER_PIN: rd_byte = user_pin_q;
      `ECSR_IDX_RSV_A: rd_byte = 8'h00;
      `ECSR_IDX_RSV_B: rd_byte = 8'h00;
      `ECSR_IDX_CTRL: rd_byte = {loop_q, bert_q, srst_cmd_q, sren_q, 4'h0};
      `ECSR_IDX_LATCH: rd_byte = latch_q;
      `ECSR_IDX_MASK: rd_byte = mask_q;
      `ECSR_IDX_REMOTE: rd_byte = {6'h00, sa_usage_select,
                                   remote_unframed_status};
      default: rd_ok = 1'b0;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `ECSR_RESP_OKAY;
    end
    else if (clk_en)
    begin
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= {24'h00_0000, rd_byte};
        s_axi_rresp <= rd_ok ? `ECSR_RESP_OKAY : `ECSR_RESP_SLVERR;
      end
      if (s_axi_rvalid && s_axi_rready)
      begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule

// ---- verif/ecsr_regs_assertions.sv ----
// concurrent checks on the ports of the e1 status/control slice
// assumes one aclk domain, synchronous active-low reset, clk_en held high
`include "ecsr_map.svh"
module ecsr_regs_assertions (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire ecsr_pkg::ecsr_ctrl_type ctrl_out,
  input wire logic irq,
  input wire logic [7:0] local_user_info_out
);
  import ecsr_pkg::*;
  localparam int SRST_CYC = `ECSR_SRST_CYCLES;
  logic [7:0] srst_cnt_q;

  // length of the current soft reset pulse
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !ctrl_out.soft_reset)
      srst_cnt_q <= 8'h00;
    else
      srst_cnt_q <= srst_cnt_q + 8'h01;
  end

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence aw_w_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence b_late;
    !s_axi_bvalid ##1 s_axi_bvalid;
  endsequence

  chk_write_answer: assert property (aw_w_taken |=> b_late)
    else $error("write response not one cycle after store");
  chk_b_stands: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before bready");
  chk_read_answer: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid && !s_axi_arready)
    else $error("read data not one cycle after address");
  chk_r_stands: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before rready");
  chk_rdata_upper: assert property (
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper read data not zero");
  chk_srst_length: assert property (
    $fell(ctrl_out.soft_reset) |-> srst_cnt_q == SRST_CYC)
    else $error("soft reset pulse has wrong length");
  chk_srst_bound: assert property (
    ctrl_out.soft_reset |-> srst_cnt_q < SRST_CYC)
    else $error("soft reset pulse too long");
  chk_srst_cause: assert property (
    $rose(ctrl_out.soft_reset) |-> $past(s_axi_bvalid))
    else $error("soft reset without a preceding write");
  // no disable here: the check is about the cycle right after release
  chk_reset_values: assert property (
    @(posedge aclk) disable iff (1'b0)
    $rose(aresetn) |-> ctrl_out == 3'b000 && !irq &&
    local_user_info_out == 8'h00)
    else $error("outputs not at reset values after release");
endmodule

// ---- verif/test_ecsr_regs.sv ----
// self-checking bench for the e1 status/control slice
// assumes ecsr_regs alone, driven over axi4-lite at 100 MHz
module test_ecsr_regs;
  timeunit 1ns;
  timeprecision 1ns;
  import ecsr_pkg::*;
  logic aclk = 1'b0;
  logic aresetn, clk_en, phy_rx_clk;
  logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [9:0] s_axi_awaddr, s_axi_araddr;
  logic [2:0] s_axi_awprot, s_axi_arprot;
  logic [31:0] s_axi_wdata, s_axi_rdata, rdv;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  ecsr_alarm_type e1_alarm;
  logic crc_err_pulse, cv_pulse, sa_usage_select, remote_valid;
  logic remote_unframed_status, irq;
  logic [15:0] strap_input_pins;
  logic [7:0] local_user_info_out;
  ecsr_ctrl_type ctrl_out;
  int n_errors = 0;
  int n_tests = 0;
  int cyc = 0;
  int phy_half = 20;

  ecsr_regs i_ecsr_regs (.*);

  always #5 aclk = ~aclk;
  // 25 MHz reads as the fast rate, 2.5 MHz as the slow one
  always #(phy_half) phy_rx_clk = ~phy_rx_clk;

  task automatic stop_test;
    if (n_errors == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  always @(posedge aclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_errors++;
      stop_test;
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // lag holds bready low for that many edges so a waiting response is seen
  task automatic wr(input logic [7:0] idx, input logic [7:0] d,
                    input int lag = 0);
    @(posedge aclk);
    s_axi_awaddr <= {idx, 2'b00};
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= (lag == 0);
    do
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (lag > 0)
      begin
        lag--;
        if (lag == 0) s_axi_bready <= 1'b1;
      end
    end
    while (!(s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1));
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] idx, input int lag = 0);
    @(posedge aclk);
    s_axi_araddr <= {idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= (lag == 0);
    do
    begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (lag > 0)
      begin
        lag--;
        if (lag == 0) s_axi_rready <= 1'b1;
      end
    end
    while (!(s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1));
    rdv = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic rc(input logic [7:0] idx, input logic [7:0] exp);
    rd(idx);
    chk(rdv, {24'h0, exp});
  endtask

  task automatic pulses(input int n, input logic [1:0] sel);
    repeat (n)
    begin
      @(posedge aclk);
      {cv_pulse, crc_err_pulse} <= sel;
      @(posedge aclk);
      {cv_pulse, crc_err_pulse} <= 2'b00;
    end
  endtask

  task automatic t_reset;
    logic [7:0] idxs [7] = '{8'h10, 8'h11, 8'h12, 8'h14, 8'h16, 8'h17, 8'h18};
    foreach (idxs[i])
      rc(idxs[i], 8'h00);
  endtask

  task automatic t_ro_writes;
    rc(8'h13, 8'ha5);
    rc(8'h15, 8'h5a);
    wr(8'h13, 8'hff);
    wr(8'h16, 8'hff);
    wr(8'h10, 8'hff);
    rc(8'h13, 8'ha5);
    rc(8'h16, 8'h00);
    rc(8'h10, 8'h00);
    rd(8'h30, 3);
    chk({30'h0, rsp}, 32'h2);
    wr(8'h30, 8'hff, 3);
    chk({30'h0, rsp}, 32'h2);
  endtask

  task automatic t_alarms;
    for (int k = 0; k < 6; k++)
    begin
      @(posedge aclk);
      e1_alarm <= 6'b10_0000 >> k;
      rd(8'h0f);
      chk(rdv & 32'hfc, 32'h80 >> k);
    end
    e1_alarm <= 6'b00_0000;
    remote_valid <= 1'b1;
    rd(8'h0f);
    chk(rdv & 32'hfd, 32'h01);
    remote_valid <= 1'b0;
    remote_unframed_status <= 1'b1;
    rc(8'h22, 8'h01);
    remote_unframed_status <= 1'b0;
    sa_usage_select <= 1'b1;
    rc(8'h22, 8'h02);
  endtask

  task automatic t_speed;
    rd(8'h0f);
    chk({31'h0, rdv[1]}, 32'h1);
    phy_half = 200;
    repeat (200) @(posedge aclk);
    rd(8'h0f);
    chk({31'h0, rdv[1]}, 32'h0);
  endtask

  task automatic t_counts;
    wr(8'h14, 8'hc3);
    repeat (2) @(posedge aclk);
    chk({24'h0, local_user_info_out}, 32'hc3);
    rc(8'h14, 8'hc3);
    pulses(3, 2'b01);
    rc(8'h10, 8'h03);
    pulses(258, 2'b10);
    rc(8'h11, 8'h01);
    rc(8'h12, 8'h02);
  endtask

  task automatic t_ctrl;
    wr(8'h18, 8'h80);
    repeat (2) @(posedge aclk);
    chk({29'h0, ctrl_out}, 32'h4);
    wr(8'h18, 8'h40);
    repeat (2) @(posedge aclk);
    chk({29'h0, ctrl_out}, 32'h2);
    wr(8'h18, 8'h20);
    repeat (2) @(posedge aclk);
    chk({29'h0, ctrl_out}, 32'h0);
    // enable and trigger together must not reset
    wr(8'h18, 8'h30);
    repeat (2) @(posedge aclk);
    chk({29'h0, ctrl_out}, 32'h0);
    rc(8'h18, 8'h10);
    rc(8'h10, 8'h03);
    wr(8'h18, 8'h30);
    repeat (2) @(posedge aclk);
    chk({31'h0, ctrl_out.soft_reset}, 32'h1);
    rc(8'h18, 8'h30);
    repeat (20) @(posedge aclk);
    rc(8'h18, 8'h10);
    rc(8'h10, 8'h00);
    rc(8'h12, 8'h00);
  endtask

  task automatic t_irq;
    wr(8'h20, 8'hff);
    wr(8'h21, 8'h80);
    e1_alarm <= 6'b10_0000;
    repeat (3) @(posedge aclk);
    e1_alarm <= 6'b00_0000;
    repeat (3) @(posedge aclk);
    chk({31'h0, irq}, 32'h1);
    rc(8'h20, 8'h80);
    wr(8'h20, 8'h80);
    repeat (2) @(posedge aclk);
    chk({31'h0, irq}, 32'h0);
    wr(8'h21, 8'h00);
    e1_alarm <= 6'b01_0000;
    repeat (3) @(posedge aclk);
    chk({31'h0, irq}, 32'h0);
    wr(8'h21, 8'h40);
    repeat (2) @(posedge aclk);
    chk({31'h0, irq}, 32'h1);
    e1_alarm <= 6'b00_0000;
    wr(8'h20, 8'h40);
    repeat (2) @(posedge aclk);
    chk({31'h0, irq}, 32'h0);
  endtask

  initial
  begin
    aresetn = 1'b0;
    clk_en = 1'b1;
    phy_rx_clk = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'b000;
    {s_axi_arvalid, s_axi_rready} = 2'b00;
    s_axi_awaddr = 10'h000;
    s_axi_araddr = 10'h000;
    s_axi_awprot = 3'b000;
    s_axi_arprot = 3'b000;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'h1;
    e1_alarm = 6'b00_0000;
    {crc_err_pulse, cv_pulse, sa_usage_select} = 3'b000;
    {remote_valid, remote_unframed_status} = 2'b00;
    strap_input_pins = 16'ha55a;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (4) @(posedge aclk);
    t_reset;
    t_ro_writes;
    t_alarms;
    t_speed;
    t_counts;
    t_ctrl;
    t_irq;
    stop_test;
  end
endmodule

bind ecsr_regs ecsr_regs_assertions i_ecsr_regs_assertions (.*);
